// ==== logic/sfc_defs.svh ====
// Register offsets, field positions, reset values and timing for the FOC sequencer
`ifndef SFC_DEFS_SVH
`define SFC_DEFS_SVH

// ==========================================================
// Timing
`define SFC_CLK_PERIOD_NS 40
`define SFC_CTRL_PERIOD_NS 20000
`define SFC_CTRL_CYC ((`SFC_CTRL_PERIOD_NS + `SFC_CLK_PERIOD_NS - 1) / `SFC_CLK_PERIOD_NS)

// ==========================================================
// Register byte offsets
`define SFC_ADDR_CTRL 8'h00
`define SFC_ADDR_LIMIT 8'h04
`define SFC_ADDR_OLACC 8'h08
`define SFC_ADDR_START 8'h0C
`define SFC_ADDR_RATE 8'h10
`define SFC_ADDR_SPDG 8'h14
`define SFC_ADDR_CURG 8'h18
`define SFC_ADDR_REF 8'h1C
`define SFC_ADDR_STAT 8'h20

// ==========================================================
// Control register fields
`define SFC_CTRL_RUN 0
`define SFC_CTRL_MTHD 1
`define SFC_CTRL_OLSEL 3
`define SFC_CTRL_AUTO 4
`define SFC_CTRL_IQRAMP 5
`define SFC_CTRL_OVM 6
`define SFC_CTRL_MEAS 7

// ==========================================================
// Reset values and scaling
`define SFC_CTRL_RST 32'h0000_0010
`define SFC_ZERO_RST 32'h0000_0000
`define SFC_OL_SHIFT 8
`define SFC_GAIN_SHIFT 8
`define SFC_DECAY_STEP 16'h0004

`endif

// ==== logic/sfc_pi.sv ====
// Proportional-integral regulator with output clamp and integrator freeze
`timescale 1ns/1ns
`include "sfc_defs.svh"
module sfc_pi
   import sfc_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clr,
   sfc_pi_if.pi pif
);
   logic signed [39:0] err_w, kp_w, ki_w, sum_w, lim_w, nlim_w, nxt_integ, integ_ff;
   logic sat_ff;
   sfc_val_t out_ff;

   // ==========================================================
   // Datapath, widened once so products cannot wrap
   always_comb begin
      err_w = 40'(pif.ref_val) - 40'(pif.meas);
      kp_w = {24'h000000, pif.kp};
      ki_w = {24'h000000, pif.ki};
      lim_w = {25'h0000000, pif.lim[14:0]};
      nlim_w = -lim_w;
      sum_w = ((kp_w * err_w) >>> `SFC_GAIN_SHIFT) + integ_ff;
      nxt_integ = integ_ff + ((ki_w * err_w) >>> `SFC_GAIN_SHIFT);
   end

   // Integrator holds while last output sat on the clamp
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         integ_ff <= 40'sh00_0000_0000;
         sat_ff <= 1'h0;
         out_ff <= 16'sh0000;
      end else if (clr) begin
         integ_ff <= 40'sh00_0000_0000;
         sat_ff <= 1'h0;
         out_ff <= 16'sh0000;
      end else if (pif.en) begin
         if (!sat_ff) begin
            integ_ff <= nxt_integ;
         end
         if (sum_w > lim_w) begin
            out_ff <= lim_w[15:0];
            sat_ff <= 1'h1;
         end else if (sum_w < nlim_w) begin
            out_ff <= nlim_w[15:0];
            sat_ff <= 1'h1;
         end else begin
            out_ff <= sum_w[15:0];
            sat_ff <= 1'h0;
         end
      end
   end

   assign pif.out = out_ff;
   assign pif.sat = sat_ff;

   out_clamp_a: assert property (@(posedge clk) disable iff (!arst_n)
      pif.en && !clr |=> (40'(pif.out) <= $past(lim_w)) && (40'(pif.out) >= $past(nlim_w)))
      else $error("regulator output beyond clamp");
   wind_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      pif.en && !clr && sat_ff |=> $stable(integ_ff))
      else $error("integrator moved while saturated");
endmodule : sfc_pi

// ==== logic/sfc_pi_if.sv ====
// Handshake bundle between the sequencer and one PI regulator
`timescale 1ns/1ns
interface sfc_pi_if;
   logic en;
   sfc_pkg::sfc_val_t ref_val;
   sfc_pkg::sfc_val_t meas;
   sfc_pkg::sfc_val_t out;
   logic [15:0] kp;
   logic [15:0] ki;
   logic [15:0] lim;
   logic sat;
   modport ctl (output en, ref_val, meas, kp, ki, lim, input out, sat);
   modport pi (input en, ref_val, meas, kp, ki, lim, output out, sat);
endinterface : sfc_pi_if

// ==== logic/sfc_pkg.sv ====
// Types shared by the FOC sequencer modules
package sfc_pkg;
   typedef enum logic [2:0] {
      ST_IDLE, ST_MEASURE, ST_INIT, ST_FIRST, ST_OPEN, ST_DECAY, ST_CLSLOW, ST_CLRUN
   } sfc_state_e;
   typedef enum logic [1:0] {SU_ALIGN, SU_DALIGN, SU_IPD, SU_SLOW} sfc_start_e;
   typedef logic signed [15:0] sfc_val_t;
endpackage : sfc_pkg

// ==== logic/sfc_slew.sv ====
// Linear ramp toward a target with a per-step limit
`timescale 1ns/1ns
module sfc_slew
   import sfc_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic en,
   input wire logic load,
   input wire sfc_val_t load_val,
   input wire sfc_val_t target,
   input wire logic [15:0] step,
   output sfc_val_t cur
);
   logic signed [16:0] diff, stp;
   sfc_val_t cur_ff;

   // ==========================================================
   // Distance to target versus allowed step
   always_comb begin
      diff = 17'(target) - 17'(cur_ff);
      stp = {1'h0, step};
   end

   // Load wins over stepping so a phase entry starts clean
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cur_ff <= 16'sh0000;
      end else if (load) begin
         cur_ff <= load_val;
      end else if (en) begin
         if (diff > stp) begin
            cur_ff <= cur_ff + step;
         end else if (diff < -stp) begin
            cur_ff <= cur_ff - step;
         end else begin
            cur_ff <= target;
         end
      end
   end

   assign cur = cur_ff;

   step_bound_a: assert property (@(posedge clk) disable iff (!arst_n)
      en && !load |=> (17'(cur_ff) - 17'($past(cur_ff)) <= $past(stp))
         && (17'($past(cur_ff)) - 17'(cur_ff) <= $past(stp)))
      else $error("ramp step larger than limit");
endmodule : sfc_slew

// ==== logic/sfc_top.sv ====
// Top of the sensorless FOC start-up sequencer with current and speed loops
//
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ns
`include "sfc_defs.svh"

// Contract
// - Method 11b starts at slow first-cycle frequency
// - First cycle only, then A1/A2 profile
// - Open loop: fixed limit, d/q PI, ramp angle
// - Open-loop speed is A1*t + A2*t*t/2
// - Open-loop limit picks general or dedicated limit
// - Auto handoff, or manual threshold when disabled
// - Theta error ramps linearly to zero
// - Iq ramp enable inserts current decay phase
// - Reference above twice handoff skips decay
// - Ramp disabled goes straight to slow acceleration
// - Slow acceleration until theta error is zero
// - Closed loop uses observer angle, zero Id
// - Speed command slews at closed-loop rate
// - Speed PI drives Iq reference, general limit
// - Speed integrator halts while output saturated
// - Both current loops share one gain pair
// - Voltage clamped to supply, integrator halts
// - D-axis loop runs before q-axis loop
// - Overmodulation enable extends PWM voltage
// - Offline measurement precedes run when enabled
// - Methods 00b, 01b, 10b: align, double, IPD
module sfc_top
   import sfc_pkg::*;
#(
   parameter int CTRL_CYC = `SFC_CTRL_CYC
) (
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire sfc_val_t ID_MEAS,
   input wire sfc_val_t IQ_MEAS,
   input wire logic [15:0] EST_THETA,
   input wire sfc_val_t EST_SPEED,
   input wire logic [15:0] VM_LIMIT,
   input wire logic HANDOFF_OK,
   input wire logic INIT_DONE,
   input wire logic PARAM_MEAS_DONE,
   output sfc_val_t VD_CMD,
   output sfc_val_t VQ_CMD,
   output logic [15:0] THETA_CMD,
   output logic INIT_REQ,
   output logic [1:0] INIT_MODE,
   output logic PARAM_MEAS_REQ,
   output logic OVERMOD_EN,
   output logic [2:0] MOTOR_STATE
);
   // ==========================================================
   // Declarations
   logic [15:0] tick_cnt_ff;
   logic tick_ff;
   logic tick_q_ff;
   logic [31:0] ctrl_ff, lim_ff, olacc_ff, start_ff, rate_ff, spdg_ff, curg_ff, ref_ff;
   logic [31:0] prdata_ff;
   logic [31:0] rd_mux;
   logic [31:0] status_w;
   logic mapped;
   logic wr_en;
   logic run, ol_sel, auto_ho, torque_current_ramp_enable, meas_en;
   sfc_start_e method;
   logic [15:0] ol_lim, first_freq, ho_thr;
   sfc_val_t speed_ref;
   sfc_state_e state_ff, nxt_state, start_st;
   logic [15:0] ol_t_ff;
   logic [47:0] ol_prod;
   logic [15:0] ol_spd;
   logic [15:0] theta_gen_ff, gen_spd;
   logic [16:0] theta_sum;
   logic [15:0] theta_cmd_ff;
   logic handoff, fast, fast_ff, decay_done, drive, in_cl;
   sfc_val_t spd_cmd, theta_err, iq_dec, dec_target, iq_ref, ol_iq;
   sfc_pi_if spd_if ();
   sfc_pi_if d_if ();
   sfc_pi_if q_if ();

   // ==========================================================
   // Control period

   // Divider; every ramp, the speed loop and the d-axis loop step on this pulse
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_cnt_ff <= 16'h0000;
         tick_ff <= 1'h0;
      end else if (tick_cnt_ff == 16'(CTRL_CYC - 1)) begin
         tick_cnt_ff <= 16'h0000;
         tick_ff <= 1'h1;
      end else begin
         tick_cnt_ff <= tick_cnt_ff + 16'h0001;
         tick_ff <= 1'h0;
      end
   end

   // q-axis step trails d-axis by one clock so Vd is settled first
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_q_ff <= 1'h0;
      end else begin
         tick_q_ff <= tick_ff;
      end
   end

   // ==========================================================
   // APB register file

   // Zero wait states; unmapped offsets answer with an error
   assign wr_en = PSEL && PENABLE && PWRITE;
   assign PREADY = 1'h1;
   assign PSLVERR = PSEL && PENABLE && !mapped;
   assign PRDATA = prdata_ff;
   assign status_w = {spd_cmd, 9'h000, q_if.sat, d_if.sat, spd_if.sat, 1'h0, state_ff};

   // Read select
   always_comb begin
      mapped = 1'h1;
      case (PADDR)
         `SFC_ADDR_CTRL: rd_mux = ctrl_ff;
         `SFC_ADDR_LIMIT: rd_mux = lim_ff;
         `SFC_ADDR_OLACC: rd_mux = olacc_ff;
         `SFC_ADDR_START: rd_mux = start_ff;
         `SFC_ADDR_RATE: rd_mux = rate_ff;
         `SFC_ADDR_SPDG: rd_mux = spdg_ff;
         `SFC_ADDR_CURG: rd_mux = curg_ff;
         `SFC_ADDR_REF: rd_mux = ref_ff;
         `SFC_ADDR_STAT: rd_mux = status_w;
         default: begin
            rd_mux = 32'h0000_0000;
            mapped = 1'h0;
         end
      endcase
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         prdata_ff <= 32'h0000_0000;
      end else if (PSEL && !PENABLE) begin
         prdata_ff <= rd_mux;
      end
   end

   // Writes land on the access edge; status ignores writes
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl_ff <= `SFC_CTRL_RST;
         lim_ff <= `SFC_ZERO_RST;
         olacc_ff <= `SFC_ZERO_RST;
         start_ff <= `SFC_ZERO_RST;
         rate_ff <= `SFC_ZERO_RST;
         spdg_ff <= `SFC_ZERO_RST;
         curg_ff <= `SFC_ZERO_RST;
         ref_ff <= `SFC_ZERO_RST;
      end else if (wr_en) begin
         case (PADDR)
            `SFC_ADDR_CTRL: ctrl_ff <= PWDATA;
            `SFC_ADDR_LIMIT: lim_ff <= PWDATA;
            `SFC_ADDR_OLACC: olacc_ff <= PWDATA;
            `SFC_ADDR_START: start_ff <= PWDATA;
            `SFC_ADDR_RATE: rate_ff <= PWDATA;
            `SFC_ADDR_SPDG: spdg_ff <= PWDATA;
            `SFC_ADDR_CURG: curg_ff <= PWDATA;
            `SFC_ADDR_REF: ref_ff <= PWDATA;
            default: ;
         endcase
      end
   end

   // Field views
   assign run = ctrl_ff[`SFC_CTRL_RUN];
   assign method = sfc_start_e'(ctrl_ff[`SFC_CTRL_MTHD +: 2]);
   assign ol_sel = ctrl_ff[`SFC_CTRL_OLSEL];
   assign auto_ho = ctrl_ff[`SFC_CTRL_AUTO];
   assign torque_current_ramp_enable = ctrl_ff[`SFC_CTRL_IQRAMP];
   assign meas_en = ctrl_ff[`SFC_CTRL_MEAS];
   assign first_freq = start_ff[15:0];
   assign ho_thr = start_ff[31:16];
   assign speed_ref = {1'h0, ref_ff[30:16]};
   assign ol_lim = ol_sel ? lim_ff[31:16] : lim_ff[15:0];
   assign ol_iq = {1'h0, ol_lim[14:0]};

   // ==========================================================
   // Open-loop ramp generator

   // Elapsed open-loop time in control periods, saturating
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ol_t_ff <= 16'h0000;
      end else if (state_ff != ST_OPEN && state_ff != ST_DECAY) begin
         ol_t_ff <= 16'h0000;
      end else if (tick_ff && ol_t_ff != 16'hFFFF) begin
         ol_t_ff <= ol_t_ff + 16'h0001;
      end
   end

   // Quadratic profile, evaluated fresh so no drift accumulates
   always_comb begin
      ol_prod = 48'(olacc_ff[15:0]) * 48'(ol_t_ff)
         + ((48'(olacc_ff[31:16]) * 48'(ol_t_ff) * 48'(ol_t_ff)) >> 1);
      ol_prod = ol_prod >> `SFC_OL_SHIFT;
      ol_spd = (ol_prod > 48'h0000_0000_7FFF) ? 16'h7FFF : ol_prod[15:0];
   end

   // First electrical cycle runs at its own fixed rate
   assign gen_spd = (state_ff == ST_FIRST) ? first_freq : ol_spd;
   assign theta_sum = {1'h0, theta_gen_ff} + {1'h0, gen_spd};

   // Generated angle; starts from zero after initialization
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         theta_gen_ff <= 16'h0000;
      end else if (state_ff inside {ST_IDLE, ST_MEASURE, ST_INIT}) begin
         theta_gen_ff <= 16'h0000;
      end else if (tick_ff && state_ff inside {ST_FIRST, ST_OPEN, ST_DECAY}) begin
         theta_gen_ff <= theta_sum[15:0];
      end
   end

   // ==========================================================
   // Sequencer

   assign start_st = (method == SU_SLOW) ? ST_FIRST : ST_INIT;
   assign handoff = tick_ff && (auto_ho ? HANDOFF_OK : (ol_spd >= ho_thr));
   assign fast = {1'h0, speed_ref} > {1'h0, ol_spd[14:0], 1'h0};
   assign decay_done = tick_ff && (iq_dec == dec_target);
   assign drive = state_ff inside {ST_FIRST, ST_OPEN, ST_DECAY, ST_CLSLOW, ST_CLRUN};
   assign in_cl = state_ff inside {ST_CLSLOW, ST_CLRUN};

   // Next phase; clearing run returns to idle from anywhere
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_IDLE: if (run) nxt_state = meas_en ? ST_MEASURE : start_st;
         ST_MEASURE: if (PARAM_MEAS_DONE) nxt_state = start_st;
         ST_INIT: if (INIT_DONE) nxt_state = ST_OPEN;
         ST_FIRST: if (tick_ff && theta_sum[16]) nxt_state = ST_OPEN;
         ST_OPEN: if (handoff) nxt_state = (torque_current_ramp_enable && !fast) ? ST_DECAY : ST_CLSLOW;
         ST_DECAY: if (decay_done) nxt_state = ST_CLSLOW;
         ST_CLSLOW: if (tick_ff && theta_err == 16'sh0000) nxt_state = ST_CLRUN;
         ST_CLRUN: nxt_state = ST_CLRUN;
         default: nxt_state = ST_IDLE;
      endcase
      if (!run) begin
         nxt_state = ST_IDLE;
      end
   end

   // Phase register
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // Remember whether handoff qualified for skipping the decay
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         fast_ff <= 1'h0;
      end else if (state_ff == ST_OPEN && handoff) begin
         fast_ff <= fast;
      end
   end

   // ==========================================================
   // Ramps

   // Speed command: slow rate until angle settles, then normal rate
   sfc_slew u_spd_slew (
      .clk(MCLK),
      .arst_n(ARST_N),
      .en(tick_ff && in_cl),
      .load(!in_cl),
      .load_val({1'h0, ol_spd[14:0]}),
      .target(speed_ref),
      .step(state_ff == ST_CLSLOW ? rate_ff[15:0] : rate_ff[31:16]),
      .cur(spd_cmd)
   );

   // Angle error, frozen on entry to ST_CLSLOW and walked linearly to zero
   sfc_slew u_theta_slew (
      .clk(MCLK),
      .arst_n(ARST_N),
      .en(tick_ff && state_ff == ST_CLSLOW),
      .load(state_ff != ST_CLSLOW),
      .load_val(theta_gen_ff - EST_THETA),
      .target(16'sh0000),
      .step(ref_ff[15:0]),
      .cur(theta_err)
   );

   // Torque current decay before closing the loop
   assign dec_target = ol_iq >>> 1;
   sfc_slew u_iq_slew (
      .clk(MCLK),
      .arst_n(ARST_N),
      .en(tick_ff && state_ff == ST_DECAY),
      .load(state_ff != ST_DECAY),
      .load_val(ol_iq),
      .target(dec_target),
      .step(`SFC_DECAY_STEP),
      .cur(iq_dec)
   );

   // ==========================================================
   // Regulators

   // Iq reference: fixed limit open loop, speed loop once closed
   always_comb begin
      case (state_ff)
         ST_FIRST, ST_OPEN: iq_ref = ol_iq;
         ST_DECAY: iq_ref = iq_dec;
         ST_CLSLOW, ST_CLRUN: iq_ref = spd_if.out;
         default: iq_ref = 16'sh0000;
      endcase
   end

   // Speed loop bounded by the general current limit
   assign spd_if.en = tick_ff && in_cl;
   assign spd_if.ref_val = spd_cmd;
   assign spd_if.meas = EST_SPEED;
   assign spd_if.kp = spdg_ff[15:0];
   assign spd_if.ki = spdg_ff[31:16];
   assign spd_if.lim = lim_ff[15:0];
   sfc_pi u_spd_pi (.clk(MCLK), .arst_n(ARST_N), .clr(!in_cl), .pif(spd_if));

   // Current loops share gains and supply clamp; Id held at zero
   assign d_if.en = tick_ff && drive;
   assign d_if.ref_val = 16'sh0000;
   assign d_if.meas = ID_MEAS;
   assign d_if.kp = curg_ff[15:0];
   assign d_if.ki = curg_ff[31:16];
   assign d_if.lim = VM_LIMIT;
   assign q_if.en = tick_q_ff && drive;
   assign q_if.ref_val = iq_ref;
   assign q_if.meas = IQ_MEAS;
   assign q_if.kp = curg_ff[15:0];
   assign q_if.ki = curg_ff[31:16];
   assign q_if.lim = VM_LIMIT;
   sfc_pi u_d_pi (.clk(MCLK), .arst_n(ARST_N), .clr(!drive), .pif(d_if));
   sfc_pi u_q_pi (.clk(MCLK), .arst_n(ARST_N), .clr(!drive), .pif(q_if));

   // ==========================================================
   // Outputs

   // Drive angle: generated, corrected estimate, then pure estimate
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         theta_cmd_ff <= 16'h0000;
      end else begin
         case (state_ff)
            ST_FIRST, ST_OPEN, ST_DECAY: theta_cmd_ff <= theta_gen_ff;
            ST_CLSLOW: theta_cmd_ff <= EST_THETA + theta_err;
            ST_CLRUN: theta_cmd_ff <= EST_THETA;
            default: theta_cmd_ff <= 16'h0000;
         endcase
      end
   end

   assign THETA_CMD = theta_cmd_ff;
   assign VD_CMD = d_if.out;
   assign VQ_CMD = q_if.out;
   assign INIT_REQ = (state_ff == ST_INIT);
   assign INIT_MODE = method;
   assign PARAM_MEAS_REQ = (state_ff == ST_MEASURE);
   assign OVERMOD_EN = ctrl_ff[`SFC_CTRL_OVM];
   assign MOTOR_STATE = state_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge MCLK);
   endclocking
   default disable iff (!ARST_N);

   sequence first_step_s;
      state_ff == ST_FIRST && tick_ff && !theta_sum[16] && run;
   endsequence
   sequence first_wrap_s;
      state_ff == ST_FIRST && tick_ff && theta_sum[16] && run;
   endsequence

   first_freq_a: assert property (first_step_s |=>
      theta_gen_ff == $past(theta_gen_ff) + $past(first_freq))
      else $error("first cycle angle step wrong");
   first_exit_a: assert property (first_wrap_s |=> state_ff == ST_OPEN)
      else $error("first cycle did not end after one turn");
   ol_limit_a: assert property (state_ff == ST_OPEN |->
      iq_ref[14:0] == (ol_sel ? lim_ff[30:16] : lim_ff[14:0]))
      else $error("open loop current limit wrong");
   manual_ho_a: assert property (state_ff == ST_OPEN && run && !auto_ho && tick_ff
      && ol_spd >= ho_thr |=> state_ff inside {ST_DECAY, ST_CLSLOW})
      else $error("manual handoff missed");
   decay_when_a: assert property (state_ff == ST_DECAY |-> torque_current_ramp_enable && !fast_ff)
      else $error("decay phase entered wrongly");
   no_decay_a: assert property (state_ff == ST_OPEN && handoff && run && !torque_current_ramp_enable
      |=> state_ff == ST_CLSLOW)
      else $error("decay phase not skipped");
   cl_angle_a: assert property ((state_ff == ST_CLRUN) [*2] |->
      THETA_CMD == $past(EST_THETA))
      else $error("closed loop angle not from observer");
   dq_order_a: assert property (d_if.en && run |=> q_if.en ##1 !q_if.en)
      else $error("q loop did not follow d loop");
   meas_hold_a: assert property (state_ff == ST_MEASURE && run && !PARAM_MEAS_DONE
      |=> state_ff == ST_MEASURE && PARAM_MEAS_REQ)
      else $error("left measurement early");
endmodule : sfc_top

// ==== tb/sfc_motor_model.sv ====
// Behavioural power stage, motor and observer seen from the controller
`timescale 1ns/1ns
module sfc_motor_model
   import sfc_pkg::*;
(
   input wire logic MCLK,
   input wire logic ARST_N,
   input wire sfc_val_t VD_CMD,
   input wire sfc_val_t VQ_CMD,
   input wire logic [15:0] THETA_CMD,
   input wire logic INIT_REQ,
   input wire logic PARAM_MEAS_REQ,
   input wire logic HOFF,
   output sfc_val_t ID_MEAS,
   output sfc_val_t IQ_MEAS,
   output logic [15:0] EST_THETA,
   output sfc_val_t EST_SPEED,
   output logic HANDOFF_OK,
   output logic INIT_DONE,
   output logic PARAM_MEAS_DONE
);
   logic [3:0] cnt_ff;
   logic [15:0] th_ff;
   // Done levels only while the request stands, never ahead of it
   assign INIT_DONE = INIT_REQ && (cnt_ff == 4'h9);
   assign PARAM_MEAS_DONE = PARAM_MEAS_REQ && (cnt_ff == 4'h9);
   // Currents lag the voltage; observer angle trails the drive angle
   always_ff @(posedge MCLK or negedge ARST_N) begin
      if (!ARST_N) begin
         cnt_ff <= 4'h0;
         th_ff <= 16'h0000;
         ID_MEAS <= 16'sh0000;
         IQ_MEAS <= 16'sh0000;
         EST_THETA <= 16'h0000;
         EST_SPEED <= 16'sh0000;
         HANDOFF_OK <= 1'b0;
      end else begin
         // Done lasts one clock so a follow-on request counts afresh
         cnt_ff <= (INIT_REQ || PARAM_MEAS_REQ)
            ? ((cnt_ff == 4'h9) ? 4'h0 : cnt_ff + 4'h1) : 4'h0;
         th_ff <= THETA_CMD;
         ID_MEAS <= VD_CMD >>> 2;
         IQ_MEAS <= VQ_CMD >>> 2;
         EST_THETA <= THETA_CMD - 16'h0300;
         EST_SPEED <= sfc_val_t'(THETA_CMD - th_ff);
         HANDOFF_OK <= HOFF;
      end
   end
endmodule : sfc_motor_model

// ==== tb/test_sfc_top.sv ====
// Self-checking bench for the FOC start-up sequencer
`timescale 1ns/1ns
`include "sfc_defs.svh"
module test_sfc_top;
   import sfc_pkg::*;
   logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, slverr, hoff, saw5;
   logic init_req, meas_req, ovm, init_done, meas_done, hok;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd, ex;
   logic [1:0] init_mode;
   logic [2:0] state;
   logic [15:0] vm, et, th, lf;
   sfc_val_t idm, iqm, es, vd, vq;
   int err_total, tests_run, cyc;
   sfc_top #(.CTRL_CYC(8)) sfc_top_inst (.MCLK(mclk), .ARST_N(arst_n), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .ID_MEAS(idm), .IQ_MEAS(iqm), .EST_THETA(et),
      .EST_SPEED(es), .VM_LIMIT(vm), .HANDOFF_OK(hok), .INIT_DONE(init_done),
      .PARAM_MEAS_DONE(meas_done), .VD_CMD(vd), .VQ_CMD(vq), .THETA_CMD(th),
      .INIT_REQ(init_req), .INIT_MODE(init_mode), .PARAM_MEAS_REQ(meas_req),
      .OVERMOD_EN(ovm), .MOTOR_STATE(state));
   sfc_motor_model sfc_motor_model_inst (.MCLK(mclk), .ARST_N(arst_n), .VD_CMD(vd),
      .VQ_CMD(vq), .THETA_CMD(th), .INIT_REQ(init_req), .PARAM_MEAS_REQ(meas_req),
      .HOFF(hoff), .ID_MEAS(idm), .IQ_MEAS(iqm), .EST_THETA(et), .EST_SPEED(es),
      .HANDOFF_OK(hok), .INIT_DONE(init_done), .PARAM_MEAS_DONE(meas_done));
   // ==========================================
   // Clock, hang guard and decay-phase watcher
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (state === 3'd5) saw5 <= 1'b1;
      else if (state === 3'd0) saw5 <= 1'b0;
      if (cyc == 60000) begin
         err_total++;
         end_of_test();
      end
   end
   // ==========================================
   // Helpers
   function logic [15:0] nxt_lf(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : nxt_lf
   // Control word: run set, method in [2:1], flags in [7:3]
   function logic [31:0] ctrl_word(input logic [1:0] m, input logic [4:0] f);
      return {24'h000000, f, m, 1'b1};
   endfunction : ctrl_word
   task chk(input string n, input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // One APB transfer; held until pready is seen at an edge
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      @(posedge mclk);
      while (pready !== 1'b1) @(posedge mclk);
      rd = prdata;
      slverr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Phase waits are bounded; a miss shows as a state mismatch
   task wst(input logic [2:0] s);
      for (int n = 0; n < 6000 && state !== s; n++) @(posedge mclk);
      chk("state", 32'(state), 32'(s));
   endtask : wst
   task end_of_test();
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test
   // ==========================================
   // Main sequence
   initial begin
      {arst_n, psel, penable, pwrite, hoff} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      vm = 16'h1000;
      lf = 16'h9D1E;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      chk("state", 32'(state), 32'h0);
      apb(1'b0, `SFC_ADDR_CTRL, 32'h0);
      chk("ctrl", rd, `SFC_CTRL_RST);
      apb(1'b0, 8'h24, 32'h0);
      chk("slverr", 32'(slverr), 32'h1);
      chk("unmapped", rd, 32'h0);
      // Random gain words must read back whole
      for (int i = 0; i < 8; i++) begin
         lf = nxt_lf(lf);
         ex = {lf, ~lf};
         apb(1'b1, i[0] ? `SFC_ADDR_CURG : `SFC_ADDR_SPDG, ex);
         apb(1'b0, i[0] ? `SFC_ADDR_CURG : `SFC_ADDR_SPDG, 32'h0);
         chk("gain", rd, ex);
      end
      // A1 = 1.0, handoff at speed 4, reference 6 stays under twice that
      apb(1'b1, `SFC_ADDR_LIMIT, 32'h0100_0200);
      apb(1'b1, `SFC_ADDR_OLACC, 32'h0000_0100);
      apb(1'b1, `SFC_ADDR_START, 32'h0004_4000);
      apb(1'b1, `SFC_ADDR_RATE, 32'h0010_0010);
      apb(1'b1, `SFC_ADDR_REF, 32'h0006_0100);
      for (int m = 0; m < 3; m++) begin
         apb(1'b1, `SFC_ADDR_CTRL, ctrl_word(2'(m), 5'h00));
         wst(3'd2);
         chk("mode", 32'(init_mode), 32'(m));
         chk("initreq", 32'(init_req), 32'h1);
         wst(3'd4);
         apb(1'b1, `SFC_ADDR_CTRL, 32'h0);
         wst(3'd0);
      end
      apb(1'b1, `SFC_ADDR_CTRL, ctrl_word(2'd3, 5'b01101));
      wst(3'd3);
      chk("overmod", 32'(ovm), 32'h1);
      wst(3'd4);
      wst(3'd5);
      wst(3'd6);
      wst(3'd7);
      apb(1'b1, `SFC_ADDR_CTRL, 32'h0);
      wst(3'd0);
      apb(1'b1, `SFC_ADDR_CTRL, ctrl_word(2'd3, 5'b00000));
      wst(3'd6);
      chk("decay", 32'(saw5), 32'h0);
      apb(1'b1, `SFC_ADDR_CTRL, 32'h0);
      wst(3'd0);
      apb(1'b1, `SFC_ADDR_REF, 32'h0040_0100);
      apb(1'b1, `SFC_ADDR_CTRL, ctrl_word(2'd3, 5'b00100));
      wst(3'd6);
      chk("decay", 32'(saw5), 32'h0);
      apb(1'b1, `SFC_ADDR_CTRL, ctrl_word(2'd0, 5'b10000));
      apb(1'b1, `SFC_ADDR_CTRL, 32'h0);
      apb(1'b1, `SFC_ADDR_CTRL, ctrl_word(2'd0, 5'b10000));
      wst(3'd1);
      chk("measreq", 32'(meas_req), 32'h1);
      wst(3'd2);
      apb(1'b1, `SFC_ADDR_CTRL, 32'h0);
      // Auto handoff ignores an unreachable manual threshold
      apb(1'b1, `SFC_ADDR_START, 32'h7FFF_4000);
      apb(1'b1, `SFC_ADDR_CTRL, ctrl_word(2'd3, 5'b00010));
      wst(3'd4);
      repeat (200) @(posedge mclk);
      chk("state", 32'(state), 32'h4);
      hoff <= 1'b1;
      wst(3'd6);
      end_of_test();
   end
endmodule : test_sfc_top
